// *** include/rtcfg_pkg.sv ***
package rtcfg_pkg;

   // Register offsets on the control port.
   localparam logic [7:0] OFS_LIFT_THERM = 8'h27;
   localparam logic [7:0] OFS_FAST_CTRL  = 8'h28;
   localparam logic [7:0] OFS_RESERVED   = 8'h29;
   localparam logic [7:0] OFS_ZERO_CROSS = 8'h2a;

   // Values after power-on reset.
   localparam logic [7:0] RST_LIFT_THERM = 8'h20;
   localparam logic [7:0] RST_FAST_CTRL  = 8'h44;
   localparam logic [7:0] RST_RESERVED   = 8'hf8;
   localparam logic [7:0] RST_ZERO_CROSS = 8'hc0;

   // Field positions inside the registers.
   localparam int LIFT_LSB     = 6;
   localparam int THERM_MSB    = 5;
   localparam int FREQ_A_BIT   = 7;
   localparam int CLAMP_A_BIT  = 6;
   localparam int EXT_A_LSB    = 4;
   localparam int FREQ_B_BIT   = 3;
   localparam int CLAMP_B_BIT  = 2;
   localparam int EXT_B_LSB    = 0;
   localparam int HYST_LSB     = 6;
   localparam int ZC_SIGN_BIT  = 5;

   // Clock period and extension step, both in picoseconds.
   localparam int CLK_PERIOD_PS = 20000;
   localparam int EXT_STEP_PS   = 625000;

   // Thermal sense voltage at 100 degrees: base minus code times step, in microvolts.
   localparam logic [20:0] THERM_BASE_UV = 21'h16_e360;
   localparam logic [11:0] THERM_STEP_UV = 12'hc35;

   // Control port serial states.
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_ADDR     = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_PTR      = 4'b0011,
      ST_PTR_ACK  = 4'b0100,
      ST_WDATA    = 4'b0101,
      ST_WR_ACK   = 4'b0110,
      ST_RDATA    = 4'b0111,
      ST_RD_ACK   = 4'b1000
   } rtcfg_state_type;

endpackage

// *** include/rtcfg_cond_if.sv ***
`timescale 1ns/10ps
// Bus conditions found on the serial pins, one-cycle pulses except the data level.
interface rtcfg_cond_if;
   logic scl_rise;   // Clock line went high.
   logic scl_fall;   // Clock line went low.
   logic start_seen; // Data fell while clock high.
   logic stop_seen;  // Data rose while clock high.
   logic sda_level;  // Synchronised data level.
   modport source (output scl_rise, output scl_fall, output start_seen, output stop_seen, output sda_level);
   modport sink   (input scl_rise, input scl_fall, input start_seen, input stop_seen, input sda_level);
endinterface

// *** hw/rtcfg_pin_cond.sv ***
`timescale 1ns/10ps
module rtcfg_pin_cond (
   // Clock and reset.
   input  wire logic     clk,
   input  wire logic     sys_rst,
   // Raw serial pins.
   input  wire logic     scl_pin,
   input  wire logic     sda_pin,
   // Found conditions.
   rtcfg_cond_if.source  cond
);

   logic [1:0] scl_sync;      // Two-stage synchroniser for the clock pin.
   logic [1:0] sda_sync;      // Two-stage synchroniser for the data pin.
   logic       scl_prev;      // Previous synchronised clock level.
   logic       sda_prev;      // Previous synchronised data level.
   logic       next_rise;
   logic       next_fall;
   logic       next_start;
   logic       next_stop;
   logic       rise_q;
   logic       fall_q;
   logic       start_q;
   logic       stop_q;

   // Conditions compare only second-stage and later levels, never the first flop.
   always_comb begin
      next_rise  = scl_sync[1] && !scl_prev;
      next_fall  = !scl_sync[1] && scl_prev;
      next_start = scl_sync[1] && scl_prev && !sda_sync[1] && sda_prev;
      next_stop  = scl_sync[1] && scl_prev && sda_sync[1] && !sda_prev;
   end

   // Idle bus reads high, so the synchronisers and previous levels reset to the released level; the condition pulses reset low.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         rise_q   <= 1'b0;
         fall_q   <= 1'b0;
         start_q  <= 1'b0;
         stop_q   <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[0], scl_pin};
         sda_sync <= {sda_sync[0], sda_pin};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
         rise_q   <= next_rise;
         fall_q   <= next_fall;
         start_q  <= next_start;
         stop_q   <= next_stop;
      end
   end

   assign cond.scl_rise   = rise_q;
   assign cond.scl_fall   = fall_q;
   assign cond.start_seen = start_q;
   assign cond.stop_seen  = stop_q;
   assign cond.sda_level  = sda_prev;

endmodule

// *** hw/rtcfg_regs.sv ***
`timescale 1ns/10ps
// Functional notes
// - Lift select codes give 1x to 2.5x.
// - Thermal voltage is 1.5V minus code times 3.125mV.
// - Frequency limit enables suppress multiple fast-mode pulses.
// - Clamp enables clamp amplifier during fast mode.
// - Extension select gives 0.625us steps up to 2.5us.
// - Hysteresis select gives 0.208mV steps.
// - Zero-cross offset is sign-magnitude, bit 5 sign.
module rtcfg_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary device address on the control port.
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Control port pins; the data enable is low while the pin is pulled low.
   input  wire logic        scl_pin,
   input  wire logic        sda_pin,
   output logic             sda_out,
   output logic             sda_oe_n,
   // Third rail settings.
   output logic [1:0]       rail_c_ramp_lift_select,
   output logic [2:0]       rail_c_lift_half_steps,
   output logic [5:0]       rail_c_thermal_offset,
   output logic [20:0]      rail_c_thermal_sense_voltage,
   output logic [1:0]       rail_c_zero_cross_hysteresis,
   output logic [5:0]       rail_c_zero_cross_offset,
   output logic signed [5:0] rail_c_zero_cross_steps,
   // First and second rail fast voltage mode settings.
   output logic             rail_a_fast_mode_freq_limit_en,
   output logic             rail_a_amp_clamp_en,
   output logic [1:0]       rail_a_extend_time_select,
   output logic [7:0]       rail_a_extend_cycles,
   output logic             rail_b_fast_mode_freq_limit_en,
   output logic             rail_b_amp_clamp_en,
   output logic [1:0]       rail_b_extend_time_select,
   output logic [7:0]       rail_b_extend_cycles,
   // Fixed pattern register, exposed for the analog trim.
   output logic [7:0]       reserved_pattern
);

   rtcfg_cond_if cond ();

   rtcfg_pin_cond u_pin_cond (
      .clk     (clk),
      .sys_rst (sys_rst),
      .scl_pin (scl_pin),
      .sda_pin (sda_pin),
      .cond    (cond)
   );

   // Extension step count for a select code, rounded down to whole cycles.
   function automatic logic [7:0] ext_cycles(input logic [1:0] sel);
      int t;
      t = (int'(sel) + 1) * rtcfg_pkg::EXT_STEP_PS / rtcfg_pkg::CLK_PERIOD_PS;
      return t[7:0];
   endfunction

   // Serial engine state.
   rtcfg_pkg::rtcfg_state_type state, next_state;
   logic [3:0] bit_cnt, next_bit_cnt;     // Bits seen in the current byte.
   logic [7:0] shift, next_shift;         // Incoming byte.
   logic [7:0] tx, next_tx;               // Outgoing byte, msb first.
   logic [7:0] ptr, next_ptr;             // Register pointer, auto-increments.
   logic       rw, next_rw;               // Read when set.
   logic       oe_n, next_oe_n;           // Open-drain enable.
   logic       wr_stb, next_wr_stb;       // One-cycle marker of a register write.

   // Register storage.
   logic [7:0] lift_therm, next_lift_therm;
   logic [7:0] fast_ctrl, next_fast_ctrl;
   logic [7:0] rsvd, next_rsvd;
   logic [7:0] zero_cross, next_zero_cross;
   logic [20:0] therm_uv, next_therm_uv;
   logic [7:0] ext_a, next_ext_a;
   logic [7:0] ext_b, next_ext_b;
   logic signed [5:0] zc_steps, next_zc_steps;
   logic [2:0] half_steps, next_half_steps; // Lift in half units, registered so the port comes from a flop.

   // Read mux; unmapped offsets read as zero.
   function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] r0,
                                         input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3);
      logic [7:0] v;
      v = 8'h00;
      if (a == rtcfg_pkg::OFS_LIFT_THERM) v = r0;
      if (a == rtcfg_pkg::OFS_FAST_CTRL) v = r1;
      if (a == rtcfg_pkg::OFS_RESERVED) v = r2;
      if (a == rtcfg_pkg::OFS_ZERO_CROSS) v = r3;
      return v;
   endfunction

   // Byte-level protocol: address, pointer, then data with auto-increment.
   // Start and stop override any state, so a confused master can always resynchronise.
   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_tx         = tx;
      next_ptr        = ptr;
      next_rw         = rw;
      next_oe_n       = oe_n;
      next_wr_stb     = 1'b0;
      next_lift_therm = lift_therm;
      next_fast_ctrl  = fast_ctrl;
      next_rsvd       = rsvd;
      next_zero_cross = zero_cross;
      if (cond.start_seen) begin
         next_state   = rtcfg_pkg::ST_ADDR;
         next_bit_cnt = 4'h0;
         next_oe_n    = 1'b1;
      end else if (cond.stop_seen) begin
         next_state = rtcfg_pkg::ST_IDLE;
         next_oe_n  = 1'b1;
      end else begin
         unique case (state)
            rtcfg_pkg::ST_IDLE: begin
               next_oe_n = 1'b1;
            end
            rtcfg_pkg::ST_ADDR, rtcfg_pkg::ST_PTR, rtcfg_pkg::ST_WDATA: begin
               if (cond.scl_rise && bit_cnt != 4'h8) begin
                  next_shift   = {shift[6:0], cond.sda_level};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (cond.scl_fall && bit_cnt == 4'h8) begin
                  next_bit_cnt = 4'h0;
                  next_oe_n    = 1'b0;
                  if (state == rtcfg_pkg::ST_ADDR) begin
                     // A foreign address is not acknowledged; wait for the next start.
                     if (shift[7:1] == DEV_ADDR) begin
                        next_rw    = shift[0];
                        next_state = rtcfg_pkg::ST_ADDR_ACK;
                     end else begin
                        next_oe_n  = 1'b1;
                        next_state = rtcfg_pkg::ST_IDLE;
                     end
                  end else if (state == rtcfg_pkg::ST_PTR) begin
                     next_ptr   = shift;
                     next_state = rtcfg_pkg::ST_PTR_ACK;
                  end else begin
                     // Whole byte lands at once; unmapped writes are acked and dropped.
                     next_wr_stb = 1'b1;
                     if (ptr == rtcfg_pkg::OFS_LIFT_THERM) next_lift_therm = shift;
                     if (ptr == rtcfg_pkg::OFS_FAST_CTRL) next_fast_ctrl = shift;
                     if (ptr == rtcfg_pkg::OFS_RESERVED) next_rsvd = shift;
                     if (ptr == rtcfg_pkg::OFS_ZERO_CROSS) next_zero_cross = shift;
                     next_ptr   = ptr + 8'h01;
                     next_state = rtcfg_pkg::ST_WR_ACK;
                  end
               end
            end
            rtcfg_pkg::ST_ADDR_ACK, rtcfg_pkg::ST_RD_ACK: begin
               if (state == rtcfg_pkg::ST_RD_ACK && cond.scl_rise && cond.sda_level) begin
                  // Master not-acknowledge ends the read burst.
                  next_state = rtcfg_pkg::ST_IDLE;
               end else if (cond.scl_fall) begin
                  if (rw) begin
                     next_tx      = rd_mux(ptr, lift_therm, fast_ctrl, rsvd, zero_cross);
                     next_oe_n    = next_tx[7];
                     next_ptr     = ptr + 8'h01;
                     next_bit_cnt = 4'h0;
                     next_state   = rtcfg_pkg::ST_RDATA;
                  end else begin
                     next_oe_n  = 1'b1;
                     next_state = rtcfg_pkg::ST_PTR;
                  end
               end
            end
            rtcfg_pkg::ST_PTR_ACK, rtcfg_pkg::ST_WR_ACK: begin
               if (cond.scl_fall) begin
                  next_oe_n  = 1'b1;
                  next_state = rtcfg_pkg::ST_WDATA;
               end
            end
            rtcfg_pkg::ST_RDATA: begin
               if (cond.scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (cond.scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     next_oe_n    = 1'b1;
                     next_bit_cnt = 4'h0;
                     next_state   = rtcfg_pkg::ST_RD_ACK;
                  end else begin
                     next_tx   = {tx[6:0], 1'b0};
                     next_oe_n = tx[6];
                  end
               end
            end
            default: begin
               next_state = rtcfg_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Decoded settings follow the stored fields one cycle later.
   always_comb begin
      // Both factors are widened first, so the product cannot wrap at twelve bits.
      next_therm_uv = rtcfg_pkg::THERM_BASE_UV
                    - 21'(lift_therm[rtcfg_pkg::THERM_MSB:0]) * 21'(rtcfg_pkg::THERM_STEP_UV);
      next_half_steps = {1'b0, lift_therm[rtcfg_pkg::LIFT_LSB +: 2]} + 3'h2;
      next_ext_a    = ext_cycles(fast_ctrl[rtcfg_pkg::EXT_A_LSB +: 2]);
      next_ext_b    = ext_cycles(fast_ctrl[rtcfg_pkg::EXT_B_LSB +: 2]);
      next_zc_steps = zero_cross[rtcfg_pkg::ZC_SIGN_BIT] ? -$signed({1'b0, zero_cross[4:0]})
                                                         : $signed({1'b0, zero_cross[4:0]});
   end

   // Registers only; reset loads the register defaults and half_steps, and clears the other decoded settings.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state      <= rtcfg_pkg::ST_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         tx         <= 8'h00;
         ptr        <= 8'h00;
         rw         <= 1'b0;
         oe_n       <= 1'b1;
         wr_stb     <= 1'b0;
         lift_therm <= rtcfg_pkg::RST_LIFT_THERM;
         fast_ctrl  <= rtcfg_pkg::RST_FAST_CTRL;
         rsvd       <= rtcfg_pkg::RST_RESERVED;
         zero_cross <= rtcfg_pkg::RST_ZERO_CROSS;
         therm_uv   <= 21'h0;
         ext_a      <= 8'h00;
         ext_b      <= 8'h00;
         zc_steps   <= 6'sh0;
         half_steps <= {1'b0, rtcfg_pkg::RST_LIFT_THERM[rtcfg_pkg::LIFT_LSB +: 2]} + 3'h2;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         tx         <= next_tx;
         ptr        <= next_ptr;
         rw         <= next_rw;
         oe_n       <= next_oe_n;
         wr_stb     <= next_wr_stb;
         lift_therm <= next_lift_therm;
         fast_ctrl  <= next_fast_ctrl;
         rsvd       <= next_rsvd;
         zero_cross <= next_zero_cross;
         therm_uv   <= next_therm_uv;
         ext_a      <= next_ext_a;
         ext_b      <= next_ext_b;
         zc_steps   <= next_zc_steps;
         half_steps <= next_half_steps;
      end
   end

   // The open-drain data line only ever pulls low.
   assign sda_out  = 1'b0;
   assign sda_oe_n = oe_n;

   assign rail_c_ramp_lift_select        = lift_therm[rtcfg_pkg::LIFT_LSB +: 2];
   assign rail_c_lift_half_steps         = half_steps;
   assign rail_c_thermal_offset          = lift_therm[rtcfg_pkg::THERM_MSB:0];
   assign rail_c_thermal_sense_voltage   = therm_uv;
   assign rail_c_zero_cross_hysteresis   = zero_cross[rtcfg_pkg::HYST_LSB +: 2];
   assign rail_c_zero_cross_offset       = zero_cross[5:0];
   assign rail_c_zero_cross_steps        = zc_steps;
   assign rail_a_fast_mode_freq_limit_en = fast_ctrl[rtcfg_pkg::FREQ_A_BIT];
   assign rail_a_amp_clamp_en            = fast_ctrl[rtcfg_pkg::CLAMP_A_BIT];
   assign rail_a_extend_time_select      = fast_ctrl[rtcfg_pkg::EXT_A_LSB +: 2];
   assign rail_a_extend_cycles           = ext_a;
   assign rail_b_fast_mode_freq_limit_en = fast_ctrl[rtcfg_pkg::FREQ_B_BIT];
   assign rail_b_amp_clamp_en            = fast_ctrl[rtcfg_pkg::CLAMP_B_BIT];
   assign rail_b_extend_time_select      = fast_ctrl[rtcfg_pkg::EXT_B_LSB +: 2];
   assign rail_b_extend_cycles           = ext_b;
   assign reserved_pattern               = rsvd;

   // Checks on the settings and the port.
   property p_lift;
      @(posedge clk) disable iff (sys_rst)
      $stable(lift_therm) |=> rail_c_lift_half_steps == 3'h2 + {1'b0, $past(rail_c_ramp_lift_select)};
   endproperty
   a_lift: assert property (p_lift) else $error("lift steps wrong");

   property p_therm;
      @(posedge clk) disable iff (sys_rst)
      $stable(lift_therm) |=> therm_uv == 21'd1500000 - 21'd3125 * 21'($past(rail_c_thermal_offset));
   endproperty
   a_therm: assert property (p_therm) else $error("thermal voltage wrong");

   property p_fast_write;
      @(posedge clk) disable iff (sys_rst)
      (wr_stb && ptr == rtcfg_pkg::OFS_FAST_CTRL + 8'h01)
      |-> rail_a_fast_mode_freq_limit_en == shift[7] && rail_b_fast_mode_freq_limit_en == shift[3];
   endproperty
   a_fast_write: assert property (p_fast_write) else $error("frequency limit enable not written");

   property p_clamp_write;
      @(posedge clk) disable iff (sys_rst)
      (wr_stb && ptr == rtcfg_pkg::OFS_FAST_CTRL + 8'h01)
      |-> rail_a_amp_clamp_en == shift[6] && rail_b_amp_clamp_en == shift[2];
   endproperty
   a_clamp_write: assert property (p_clamp_write) else $error("clamp enable not written");

   property p_ext;
      @(posedge clk) disable iff (sys_rst)
      ($stable(fast_ctrl) && rail_a_extend_time_select == 2'h3) |=> rail_a_extend_cycles == 8'd125;
   endproperty
   a_ext: assert property (p_ext) else $error("extension cycles wrong");

   property p_hyst_hold;
      @(posedge clk) disable iff (sys_rst)
      !wr_stb |-> $stable(rail_c_zero_cross_hysteresis);
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis changed without write");

   property p_zc_sign;
      @(posedge clk) disable iff (sys_rst)
      $stable(zero_cross) ##1 $stable(zero_cross)
      |-> (zero_cross[5] ? (zc_steps <= 0) : (zc_steps >= 0)) && (zc_steps == 0 || zc_steps[5] == zero_cross[5]);
   endproperty
   a_zc_sign: assert property (p_zc_sign) else $error("offset sign wrong");

   property p_reset;
      @(posedge clk)
      sys_rst |=> fast_ctrl == 8'h44 && lift_therm == 8'h20 && zero_cross == 8'hc0 && sda_oe_n;
   endproperty
   a_reset: assert property (p_reset) else $error("reset defaults wrong");

   property p_rsvd_reset;
      @(posedge clk)
      sys_rst |=> reserved_pattern == 8'hf8;
   endproperty
   a_rsvd_reset: assert property (p_rsvd_reset) else $error("fixed pattern default wrong");

   property p_addr_ack;
      @(posedge clk) disable iff (sys_rst)
      (state == rtcfg_pkg::ST_ADDR && cond.scl_fall && bit_cnt == 4'h8 && shift[7:1] == DEV_ADDR
       && !cond.start_seen && !cond.stop_seen) |=> !sda_oe_n && state == rtcfg_pkg::ST_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

endmodule

// *** verif/rtcfg_host.sv ***
`timescale 1ns/10ps
module rtcfg_host #(
   parameter logic [6:0] DEV = 7'h20 // Address the design answers to.
) (
   // Clock.
   input  wire logic clk,
   // Serial pins; sda_rel high lets the pulled-up line float.
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_rel
);
   // Idle bus from time zero.
   initial begin
      scl = 1'h1;
      sda_rel = 1'h1;
   end

   // Every pin move lands on a falling edge, clear of the design's sampling edge.
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Start or repeated start; six cycles of margin cover the synchroniser delay.
   task automatic start_cond();
      sda_rel = 1'h1;
      hold(6);
      scl = 1'h1;
      hold(6);
      sda_rel = 1'h0;
      hold(6);
      scl = 1'h0;
      hold(6);
   endtask

   // Stop condition, leaving the bus idle.
   task automatic stop_cond();
      sda_rel = 1'h0;
      hold(6);
      scl = 1'h1;
      hold(6);
      sda_rel = 1'h1;
      hold(6);
   endtask

   // One bit each way; the line is sampled in mid clock-high, long after the design's data moves.
   task automatic bit_x(input logic b, output logic got);
      sda_rel = b;
      hold(6);
      scl = 1'h1;
      hold(6);
      got = sda_wire;
      hold(6);
      scl = 1'h0;
      hold(6);
   endtask

   // A whole byte, most significant bit first, then the acknowledge slot.
   task automatic byte_x(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(ab, a);
   endtask

   // Pointer then one data byte; nk is high if any byte went unacknowledged.
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic nk);
      logic [7:0] q;
      logic       a0;
      logic       a1;
      logic       a2;
      start_cond();
      byte_x({DEV, 1'h0}, 1'h1, q, a0);
      byte_x(ptr, 1'h1, q, a1);
      byte_x(d, 1'h1, q, a2);
      stop_cond();
      nk = a0 | a1 | a2;
   endtask

   // Burst read of n bytes from ptr; the last byte is refused to end the burst.
   task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q [$]);
      logic [7:0] t;
      logic       a;
      q = {};
      start_cond();
      byte_x({DEV, 1'h0}, 1'h1, t, a);
      byte_x(ptr, 1'h1, t, a);
      start_cond();
      byte_x({DEV, 1'h1}, 1'h1, t, a);
      for (int k = 0; k < n; k++) begin
         byte_x(8'hff, 1'(k == n - 1), t, a);
         q.push_back(t);
      end
      stop_cond();
   endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   // Clock, reset and serial pins; the data wire is pulled up and wired-and.
   logic              clk;
   logic              sys_rst;
   logic              scl_pin;
   logic              sda_rel;
   logic              sda_out;
   logic              sda_oe_n;
   wire logic         sda_pin;
   // Design outputs.
   logic [1:0]        rail_c_ramp_lift_select;
   logic [2:0]        rail_c_lift_half_steps;
   logic [5:0]        rail_c_thermal_offset;
   logic [20:0]       rail_c_thermal_sense_voltage;
   logic [1:0]        rail_c_zero_cross_hysteresis;
   logic [5:0]        rail_c_zero_cross_offset;
   logic signed [5:0] rail_c_zero_cross_steps;
   logic              rail_a_fast_mode_freq_limit_en;
   logic              rail_a_amp_clamp_en;
   logic [1:0]        rail_a_extend_time_select;
   logic [7:0]        rail_a_extend_cycles;
   logic              rail_b_fast_mode_freq_limit_en;
   logic              rail_b_amp_clamp_en;
   logic [1:0]        rail_b_extend_time_select;
   logic [7:0]        rail_b_extend_cycles;
   logic [7:0]        reserved_pattern;
   // Reference copy of the four registers, counters and scratch.
   logic [7:0]        mdl [4];
   logic [7:0]        q [$];
   logic [7:0]        v0;
   logic [7:0]        v1;
   logic [7:0]        v3;
   logic              a;
   int                err_total;
   int                tests_run;
   int                cyc;
   int                seed;

   assign sda_pin = sda_rel & (sda_oe_n | sda_out);

   rtcfg_host i_rtcfg_host (.clk, .sda_wire(sda_pin), .scl(scl_pin), .sda_rel);

   rtcfg_regs i_rtcfg_regs (.clk, .sys_rst, .scl_pin, .sda_pin, .sda_out, .sda_oe_n, .rail_c_ramp_lift_select,
      .rail_c_lift_half_steps, .rail_c_thermal_offset, .rail_c_thermal_sense_voltage, .rail_c_zero_cross_hysteresis,
      .rail_c_zero_cross_offset, .rail_c_zero_cross_steps, .rail_a_fast_mode_freq_limit_en, .rail_a_amp_clamp_en,
      .rail_a_extend_time_select, .rail_a_extend_cycles, .rail_b_fast_mode_freq_limit_en, .rail_b_amp_clamp_en,
      .rail_b_extend_time_select, .rail_b_extend_cycles, .reserved_pattern);

   // Free-running clock at 50 MHz.
   initial clk = 1'h0;
   always #10 clk = ~clk;

   // Guards against a hung handshake; the whole sequence needs about 40000 cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc >= 80000) begin
         err_total++;
         final_report();
      end
   end

   task automatic final_report();
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Writes one register and mirrors it in the reference when it is mapped.
   task automatic put(input logic [7:0] ptr, input logic [7:0] d);
      logic nk;
      i_rtcfg_host.wr(ptr, d, nk);
      chk("write ack", 32'h0, 32'(nk));
      if (ptr inside {[8'h27:8'h2a]}) mdl[ptr - 8'h27] = d;
   endtask

   // Compares every output with the reference, then reads all four back in one burst.
   task automatic check_all();
      chk("lift select", mdl[0][7:6], rail_c_ramp_lift_select);
      chk("lift half steps", mdl[0][7:6] + 2, rail_c_lift_half_steps);
      chk("thermal offset", mdl[0][5:0], rail_c_thermal_offset);
      chk("thermal volts", rtcfg_pkg::THERM_BASE_UV - mdl[0][5:0] * rtcfg_pkg::THERM_STEP_UV, rail_c_thermal_sense_voltage);
      chk("freq limit a", mdl[1][7], rail_a_fast_mode_freq_limit_en);
      chk("freq limit b", mdl[1][3], rail_b_fast_mode_freq_limit_en);
      chk("clamp a", mdl[1][6], rail_a_amp_clamp_en);
      chk("clamp b", mdl[1][2], rail_b_amp_clamp_en);
      chk("extend a", mdl[1][5:4], rail_a_extend_time_select);
      chk("extend b", mdl[1][1:0], rail_b_extend_time_select);
      chk("cycles a", (mdl[1][5:4] + 1) * rtcfg_pkg::EXT_STEP_PS / rtcfg_pkg::CLK_PERIOD_PS, rail_a_extend_cycles);
      chk("cycles b", (mdl[1][1:0] + 1) * rtcfg_pkg::EXT_STEP_PS / rtcfg_pkg::CLK_PERIOD_PS, rail_b_extend_cycles);
      chk("hysteresis", mdl[3][7:6], rail_c_zero_cross_hysteresis);
      chk("zc offset", mdl[3][5:0], rail_c_zero_cross_offset);
      chk("zc steps", mdl[3][5] ? -32'(mdl[3][4:0]) : 32'(mdl[3][4:0]), 32'(rail_c_zero_cross_steps));
      chk("reserved", mdl[2], reserved_pattern);
      i_rtcfg_host.rd(8'h27, 4, q);
      foreach (q[k]) chk("readback", mdl[k], q[k]);
   endtask

   // Reset held three cycles, then the defaults are expected everywhere.
   task automatic do_reset();
      sys_rst = 1'h1;
      repeat (3) @(negedge clk);
      sys_rst = 1'h0;
      repeat (4) @(negedge clk);
      mdl = '{8'h20, 8'h44, 8'hf8, 8'hc0};
      check_all();
   endtask

   initial begin
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      seed = $urandom(85);
      do_reset();
      // Every code of each two-bit field, random elsewhere, back to back.
      for (int i = 0; i < 8; i++) begin
         v0 = {2'(i), 6'($urandom)};
         v1 = 8'($urandom);
         v1[5:4] = 2'(i);
         v1[1:0] = 2'(3 - i);
         v3 = {2'(i), 6'($urandom)};
         put(8'h27, v0);
         put(8'h28, v1);
         put(8'h2a, v3);
         check_all();
      end
      // Host keeps the reserved register at its fixed pattern.
      put(8'h29, 8'hf8);
      check_all();
      // Unmapped offset: accepted, dropped, reads as zero.
      put(8'h2b, 8'h5a);
      i_rtcfg_host.rd(8'h2b, 1, q);
      chk("unmapped read", 32'h0, 32'(q[0]));
      // Foreign address must go unanswered.
      i_rtcfg_host.start_cond();
      i_rtcfg_host.byte_x(8'h42, 1'h1, v0, a);
      i_rtcfg_host.stop_cond();
      chk("foreign address", 32'h1, 32'(a));
      // Reset in mid-run after settings were changed.
      do_reset();
      final_report();
   end
endmodule
